// File: design/pcet_consts.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 pulse capture / event timer channel. Assumes inclusion by bare name.
*/
`ifndef PCET_CONSTS_SVH
`define PCET_CONSTS_SVH

// Register word addresses on the plain register port
`define PCET_A_MODE_CTL 4'h0
`define PCET_A_CAPTURE_CTL 4'h1
`define PCET_A_PRESCALE 4'h2
`define PCET_A_OUTPUT_CTL 4'h3
`define PCET_A_CMP_FIRST 4'h4
`define PCET_A_CMP_SECOND 4'h5
`define PCET_A_MAIN_COUNT 4'h6
`define PCET_A_STATUS 4'h7

// mode_ctl fields: op mode in bits 3:2; wrap_flag is bit 0 of the status register
`define PCET_MODE_LO 2
`define PCET_MODE_HI 3
`define PCET_WRAP_BIT 0
// Operating mode codes in op_mode bits
`define PCET_OPM_STOP 2'h0
`define PCET_OPM_RESTART 2'h1
`define PCET_OPM_CLEAR 2'h2
`define PCET_OPM_FREE 2'h3

// capture_ctl fields
`define PCET_CRC_CAP_FIRST 0
`define PCET_CRC_SECOND_OPP 1
`define PCET_CRC_CAP_SECOND 2

// prescale_edge_ctl fields
`define PCET_PRS_CLK_LO 0
`define PCET_PRS_ES_FIRST 4
`define PCET_PRS_ES_SECOND 6

// output_ctl fields
`define PCET_TOC_ENABLE 0
`define PCET_TOC_TOGGLE 1

// Edge select codes
`define PCET_ES_FALL 2'h0
`define PCET_ES_RISE 2'h1
`define PCET_ES_BOTH 2'h3

// Prescaler divides of the base clock (log2)
`define PCET_DIV_SEL1 4'h2
`define PCET_DIV_SEL2 4'h8

`define PCET_MAX_COUNT 16'hffff
`define PCET_RESET_BYTE 8'h00
`define PCET_RESET_WORD 16'h0000

`endif

// File: design/pcet_pkg.sv
/*
 Types shared by the pulse capture / event timer channel.
 Assumes the constants header is compiled alongside.
*/
package pcet_pkg;

  typedef enum logic [1:0] {
    pcet_stop,
    pcet_restart,
    pcet_clear_match,
    pcet_free
  } pcet_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pcet_bus_req_t;

  typedef struct packed {
    logic trig_in_first;
    logic trig_in_second;
  } pcet_pins_t;

endpackage

// File: design/pcet_timer.sv
/*
 Sixteen-bit capture/compare timer channel: pulse width capture, external
 event counting and square-wave output, all in one module.
 Assumes input pins synchronous to clock and a register master that
 follows the one-cycle strobe protocol with read data one cycle later.
*/
`timescale 1ns/1ps
`include "pcet_consts.svh"

module pcet_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire pcet_pkg::pcet_bus_req_t bus_req,
  output logic [15:0] rdata,
  // Pins
  input wire pcet_pkg::pcet_pins_t pins,
  output logic wave_out,
  output logic first_reg_irq,
  output logic second_reg_irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] mode_ctl_reg;
  logic [7:0] capture_ctl_reg;
  logic [7:0] prescale_edge_ctl_reg;
  logic [7:0] output_ctl_reg;
  logic [15:0] cmp_cap_first_reg;
  logic [15:0] cmp_cap_second_reg;
  logic [15:0] main_count_reg;
  logic wrap_flag_reg;
  logic [8:0] div_reg;
  logic tick_reg;
  logic [1:0] samp_first_reg;
  logic [1:0] samp_second_reg;
  logic lvl_first_reg;
  logic lvl_second_reg;
  logic [15:0] rdata_reg;
  logic wave_reg;
  logic irq_first_reg;
  logic irq_second_reg;

  pcet_pkg::pcet_mode_t mode;
  logic [1:0] es_first;
  logic [1:0] es_second;
  logic event_mode;
  logic samp_en;
  logic new_first;
  logic new_second;
  logic edge_first;
  logic edge_opp_first;
  logic edge_second;
  logic match_first;
  logic at_max;
  logic count_step;
  logic restart_cap;
  logic clear_cnt;
  logic cap_into_second;
  logic cap_into_first;
  logic wrap_set;
  logic match_clear;

  // Edge qualifier shared by both pins
  function automatic logic edge_ok(input logic [1:0] es, input logic prev,
                                   input logic now);
    case (es)
      `PCET_ES_FALL: edge_ok = prev & ~now;
      `PCET_ES_RISE: edge_ok = ~prev & now;
      `PCET_ES_BOTH: edge_ok = prev ^ now;
      default: edge_ok = 1'b0;
    endcase
  endfunction

  assign mode = pcet_pkg::pcet_mode_t'(mode_ctl_reg[`PCET_MODE_HI:`PCET_MODE_LO]);
  assign es_first = prescale_edge_ctl_reg[`PCET_PRS_ES_FIRST +: 2];
  assign es_second = prescale_edge_ctl_reg[`PCET_PRS_ES_SECOND +: 2];
  // Clock select 3 marks event counting of the first pin
  assign event_mode = (prescale_edge_ctl_reg[1:0] == 2'h3);

  ////////////////////////////////////////////////////////////////////////////
  // Count clock prescaler; clock select 0 runs at the base clock
  always_ff @(posedge clock) begin
    if (!resetn || mode == pcet_pkg::pcet_stop) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_reg + 9'h001;
      case (prescale_edge_ctl_reg[1:0])
        2'h0: tick_reg <= 1'b1;
        2'h1: tick_reg <= (div_reg[`PCET_DIV_SEL1 - 4'h1:0] == '1);
        2'h2: tick_reg <= (div_reg[`PCET_DIV_SEL2 - 4'h1:0] == '1);
        default: tick_reg <= 1'b0;
      endcase
    end
  end

  // Event mode samples on every base clock, otherwise on the count clock
  assign samp_en = event_mode | tick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Noise filter: a level counts only after two equal samples
  always_ff @(posedge clock) begin
    if (!resetn) begin
      samp_first_reg <= 2'h0;
      samp_second_reg <= 2'h0;
      lvl_first_reg <= 1'b0;
      lvl_second_reg <= 1'b0;
    end else if (samp_en) begin
      samp_first_reg <= {samp_first_reg[0], pins.trig_in_first};
      samp_second_reg <= {samp_second_reg[0], pins.trig_in_second};
      if (samp_first_reg[1] == samp_first_reg[0]) begin
        lvl_first_reg <= samp_first_reg[0];
      end
      if (samp_second_reg[1] == samp_second_reg[0]) begin
        lvl_second_reg <= samp_second_reg[0];
      end
    end
  end

  assign new_first = (samp_first_reg[1] == samp_first_reg[0]) ? samp_first_reg[0]
                                                               : lvl_first_reg;
  assign new_second = (samp_second_reg[1] == samp_second_reg[0]) ? samp_second_reg[0]
                                                                 : lvl_second_reg;
  assign edge_first = samp_en & edge_ok(es_first, lvl_first_reg, new_first);
  // Opposite of rise is fall and back; both and none have no opposite edge
  assign edge_opp_first = samp_en & ~es_first[1]
                        & edge_ok({1'b0, ~es_first[0]}, lvl_first_reg, new_first);
  assign edge_second = samp_en & edge_ok(es_second, lvl_second_reg, new_second);

  ////////////////////////////////////////////////////////////////////////////
  // Counter control
  assign match_first = (main_count_reg == cmp_cap_first_reg)
                     & ~capture_ctl_reg[`PCET_CRC_CAP_FIRST];
  assign at_max = (main_count_reg == `PCET_MAX_COUNT);
  assign count_step = event_mode ? edge_first : tick_reg;
  assign restart_cap = (mode == pcet_pkg::pcet_restart) & edge_first;
  assign match_clear = (mode == pcet_pkg::pcet_clear_match) & match_first
                     & count_step;
  assign clear_cnt = restart_cap | match_clear;
  // A match at the maximum count also passes through zero, so it wraps too
  assign wrap_set = (mode != pcet_pkg::pcet_stop) & count_step & at_max
                  & ~restart_cap;
  assign cap_into_second = (mode != pcet_pkg::pcet_stop) & ~event_mode
                         & capture_ctl_reg[`PCET_CRC_CAP_SECOND] & edge_first;
  assign cap_into_first = (mode != pcet_pkg::pcet_stop) & ~event_mode
                        & capture_ctl_reg[`PCET_CRC_CAP_FIRST]
                        & (capture_ctl_reg[`PCET_CRC_SECOND_OPP] ? edge_opp_first
                                                                  : edge_second);

  always_ff @(posedge clock) begin
    if (!resetn || mode == pcet_pkg::pcet_stop) begin
      main_count_reg <= `PCET_RESET_WORD;
    end else if (clear_cnt) begin
      main_count_reg <= `PCET_RESET_WORD;
    end else if (count_step) begin
      main_count_reg <= main_count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture registers; a capture wins over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cmp_cap_first_reg <= `PCET_RESET_WORD;
    end else if (cap_into_first) begin
      cmp_cap_first_reg <= main_count_reg;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_CMP_FIRST) begin
      cmp_cap_first_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cmp_cap_second_reg <= `PCET_RESET_WORD;
    end else if (cap_into_second) begin
      cmp_cap_second_reg <= main_count_reg;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_CMP_SECOND) begin
      cmp_cap_second_reg <= bus_req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses and square wave
  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_first_reg <= 1'b0;
    end else begin
      irq_first_reg <= (cap_into_first & ~capture_ctl_reg[`PCET_CRC_SECOND_OPP])
                     | match_clear;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_second_reg <= 1'b0;
    end else begin
      irq_second_reg <= cap_into_second;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn || !output_ctl_reg[`PCET_TOC_ENABLE]) begin
      wave_reg <= 1'b0;
    end else if (output_ctl_reg[`PCET_TOC_TOGGLE] && match_clear) begin
      wave_reg <= ~wave_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; wrap flag set wins over software clear
  always_ff @(posedge clock) begin
    if (!resetn) begin
      mode_ctl_reg <= `PCET_RESET_BYTE;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_MODE_CTL) begin
      mode_ctl_reg <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      capture_ctl_reg <= `PCET_RESET_BYTE;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_CAPTURE_CTL) begin
      capture_ctl_reg <= bus_req.wdata[7:0];
    end
  end

  // Edge select is not guarded: changing it while counting may fake an edge
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prescale_edge_ctl_reg <= `PCET_RESET_BYTE;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_PRESCALE) begin
      prescale_edge_ctl_reg <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      output_ctl_reg <= `PCET_RESET_BYTE;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_OUTPUT_CTL) begin
      output_ctl_reg <= bus_req.wdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrap_flag_reg <= 1'b0;
    end else if (wrap_set) begin
      wrap_flag_reg <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_STATUS
                 && !bus_req.wdata[`PCET_WRAP_BIT]) begin
      wrap_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (!resetn || !bus_req.rd) begin
      rdata_reg <= `PCET_RESET_WORD;
    end else begin
      case (bus_req.addr)
        `PCET_A_MODE_CTL: rdata_reg <= {8'h00, mode_ctl_reg};
        `PCET_A_CAPTURE_CTL: rdata_reg <= {8'h00, capture_ctl_reg};
        `PCET_A_PRESCALE: rdata_reg <= {8'h00, prescale_edge_ctl_reg};
        `PCET_A_OUTPUT_CTL: rdata_reg <= {8'h00, output_ctl_reg};
        `PCET_A_CMP_FIRST: rdata_reg <= cmp_cap_first_reg;
        `PCET_A_CMP_SECOND: rdata_reg <= cmp_cap_second_reg;
        `PCET_A_MAIN_COUNT: rdata_reg <= main_count_reg;
        `PCET_A_STATUS: rdata_reg <= {15'h0000, wrap_flag_reg};
        default: rdata_reg <= `PCET_RESET_WORD;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign wave_out = wave_reg;
  assign first_reg_irq = irq_first_reg;
  assign second_reg_irq = irq_second_reg;

endmodule

// File: test/pcet_timer_asserts.sv
/*
 Port checker for the capture/event timer channel.
 Assumes it is bound to pcet_timer and sees only its ports.
*/
`timescale 1ns/1ps
`include "pcet_consts.svh"
module pcet_timer_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire pcet_pkg::pcet_bus_req_t bus_req,
  input wire logic [15:0] rdata,
  // Pins
  input wire pcet_pkg::pcet_pins_t pins,
  input wire logic wave_out,
  input wire logic first_reg_irq,
  input wire logic second_reg_irq
);
  logic ena_reg;
  logic fast_reg;
  logic [3:0] quiet_reg;
  pcet_pkg::pcet_pins_t pins_reg;
  // Shadow bits; slow prescale is excluded since its edges arrive late
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ena_reg <= 1'b0;
      fast_reg <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `PCET_A_OUTPUT_CTL) begin
      ena_reg <= bus_req.wdata[`PCET_TOC_ENABLE];
    end else if (bus_req.wr && bus_req.addr == `PCET_A_PRESCALE) begin
      fast_reg <= bus_req.wdata[0] == bus_req.wdata[1];
    end
  end
  // Cycles since the pins last moved
  always_ff @(posedge clock) begin
    pins_reg <= pins;
    if (!resetn || pins != pins_reg) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_wr(a); bus_req.wr && bus_req.addr == a; endsequence
  sequence s_rd(a); bus_req.rd && bus_req.addr == a; endsequence
  property p_rd_idle; !(bus_req.rd && !bus_req.addr[3]) |=> rdata == 16'h0000; endproperty
  property p_cmp_back;
    s_wr(`PCET_A_CMP_FIRST) ##1 s_rd(`PCET_A_CMP_FIRST) |=> rdata == $past(bus_req.wdata, 2);
  endproperty
  property p_wrap_clr;
    s_wr(`PCET_A_STATUS) ##0 !bus_req.wdata[0] ##1 s_rd(`PCET_A_STATUS) |=> !rdata[0];
  endproperty
  property p_irq1; first_reg_irq |=> !first_reg_irq; endproperty
  property p_irq2; second_reg_irq |=> !second_reg_irq; endproperty
  property p_quiet; fast_reg && quiet_reg >= 4'ha |-> !second_reg_irq; endproperty
  property p_wave_off; (!ena_reg)[*2] |-> !wave_out; endproperty
  property p_mode_hi; s_rd(`PCET_A_MODE_CTL) |=> rdata[15:8] == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  a_cmp_back: assert property (p_cmp_back) else $error("compare readback");
  a_wrap_clr: assert property (p_wrap_clr) else $error("wrap not cleared");
  a_irq1: assert property (p_irq1) else $error("first irq long");
  a_irq2: assert property (p_irq2) else $error("second irq long");
  a_quiet: assert property (p_quiet) else $error("capture without edge");
  a_wave_off: assert property (p_wave_off) else $error("wave while off");
  a_mode_hi: assert property (p_mode_hi) else $error("mode high byte");
endmodule
bind pcet_timer pcet_timer_asserts i_pcet_timer_asserts (.clock(clock), .resetn(resetn),
  .bus_req(bus_req), .rdata(rdata), .pins(pins), .wave_out(wave_out),
  .first_reg_irq(first_reg_irq), .second_reg_irq(second_reg_irq));

// File: test/pcet_pulse_src.sv
/*
 Pulse source standing in for the signals on the two trigger pins.
 Assumes the bench sets levels and spike on the rising edge.
*/
`timescale 1ns/1ps
module pcet_pulse_src (
  // Clock
  input wire logic clock,
  // Requested levels
  input wire logic lvl_first,
  input wire logic lvl_second,
  input wire logic spike,
  // Pins
  output pcet_pkg::pcet_pins_t pins = '0
);
  // A spike lasts one clock, shorter than the input filter accepts
  always @(posedge clock) begin
    pins.trig_in_first <= lvl_first ^ spike;
    pins.trig_in_second <= lvl_second;
  end
endmodule

// File: test/pcet_timer_tb.sv
/*
 Self-checking bench for the timer channel.
 Assumes the checker binds itself and the pulse source drives the pins.
*/
`timescale 1ns/1ps
`include "pcet_consts.svh"
module pcet_timer_tb;
  typedef struct {logic [1:0] es; int k; logic [15:0] exp;} pcet_row_t;
  pcet_row_t rows [3] = '{'{`PCET_ES_FALL, 3, 16'h0003}, '{`PCET_ES_RISE, 3, 16'h0003},
    '{`PCET_ES_BOTH, 3, 16'h0006}};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic lvl_first = 1'b0, lvl_second = 1'b0, spike = 1'b0;
  pcet_pkg::pcet_bus_req_t bus_req = '0;
  pcet_pkg::pcet_pins_t pins;
  logic [15:0] rdata, v0, v1;
  logic wave_out, first_reg_irq, second_reg_irq, wq;
  int n_errors = 0, comparisons = 0, cyc = 0, n1 = 0, n2 = 0, t0, c0;
  int tw = 0, ti = 0, per_w = 0, per_i = 0;
  pcet_timer i_pcet_timer (.clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .pins(pins), .wave_out(wave_out), .first_reg_irq(first_reg_irq),
    .second_reg_irq(second_reg_irq));
  pcet_pulse_src i_pcet_pulse_src (.clock(clock), .lvl_first(lvl_first),
    .lvl_second(lvl_second), .spike(spike), .pins(pins));
  always #2.5 clock = ~clock;
  // Pulse counts and periods, plus the hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    wq <= wave_out;
    if (first_reg_irq === 1'b1) begin
      n1 <= n1 + 1;
      per_i <= cyc - ti;
      ti <= cyc;
    end
    if (second_reg_irq === 1'b1) begin
      n2 <= n2 + 1;
    end
    if (wave_out !== wq) begin
      per_w <= cyc - tw;
      tw <= cyc;
    end
    if (cyc == 80000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Every write is read back at once so the checker sees it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req <= '{a, d, 1'b0, 1'b1};
    @(posedge clock);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1 v = rdata;
  endtask
  task automatic cfg(input logic [1:0] m, input logic [15:0] p, c, o, k);
    wr(`PCET_A_MODE_CTL, 16'h0000);
    wr(`PCET_A_PRESCALE, p);
    wr(`PCET_A_CAPTURE_CTL, c);
    wr(`PCET_A_OUTPUT_CTL, o);
    wr(`PCET_A_CMP_FIRST, k);
    wr(`PCET_A_MODE_CTL, {12'h000, m, 2'h0});
  endtask
  task automatic pin(input bit s, input logic l);
    @(posedge clock);
    if (s) lvl_second <= l;
    else lvl_first <= l;
  endtask
  // Width between the two captures must equal the driven pulse width
  task automatic meas(input bit s);
    c0 = s ? n1 : n2;
    pin(s, 1'b1);
    t0 = cyc;
    w(12);
    rd(s ? `PCET_A_CMP_FIRST : `PCET_A_CMP_SECOND, v0);
    pin(s, 1'b0);
    t0 = cyc - t0;
    w(12);
    rd(s ? `PCET_A_CMP_FIRST : `PCET_A_CMP_SECOND, v1);
    chk(v1 - v0, 16'(t0));
    chk(16'((s ? n1 : n2) - c0), 16'h0002);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], v0);
      chk(v0, `PCET_RESET_WORD);
    end
    foreach (rows[r]) begin
      cfg(`PCET_OPM_CLEAR, {10'h000, rows[r].es, 4'h3}, 0, 0, 16'h0010);
      repeat (rows[r].k) begin
        pin(0, 1'b1);
        w(3);
        pin(0, 1'b0);
        w(3);
      end
      w(4);
      rd(`PCET_A_MAIN_COUNT, v0);
      chk(v0, rows[r].exp);
    end
    cfg(`PCET_OPM_CLEAR, 16'h0013, 0, 0, 16'h0003);
    c0 = n1;
    repeat (4) begin
      pin(0, 1'b1);
      w(3);
      pin(0, 1'b0);
      w(3);
    end
    w(4);
    rd(`PCET_A_MAIN_COUNT, v0);
    chk(v0, 16'h0000);
    chk(16'(n1 - c0), 16'h0001);
    rd(`PCET_A_STATUS, v0);
    chk(v0, 16'h0000);
    cfg(`PCET_OPM_FREE, 16'h00f0, 16'h0005, 0, 0);
    meas(0);
    meas(1);
    c0 = n2;
    @(posedge clock);
    spike <= 1'b1;
    @(posedge clock);
    spike <= 1'b0;
    w(12);
    chk(16'(n2 - c0), 16'h0000);
    cfg(`PCET_OPM_FREE, 16'h0010, 16'h0007, 0, 0);
    c0 = n2;
    pin(0, 1'b1);
    t0 = cyc;
    w(30);
    pin(0, 1'b0);
    t0 = cyc - t0;
    w(12);
    rd(`PCET_A_CMP_FIRST, v0);
    rd(`PCET_A_CMP_SECOND, v1);
    chk(v0 - v1, 16'(t0));
    chk(16'(n2 - c0), 16'h0001);
    cfg(`PCET_OPM_RESTART, 16'h0010, 16'h0005, 0, 0);
    w(40);
    c0 = n2;
    pin(0, 1'b1);
    w(8);
    rd(`PCET_A_MAIN_COUNT, v0);
    rd(`PCET_A_CMP_SECOND, v1);
    chk({15'h0, v0 < 16'h0010}, 16'h0001);
    chk({15'h0, v1 > 16'h0028}, 16'h0001);
    chk(16'(n2 - c0), 16'h0001);
    pin(0, 1'b0);
    cfg(`PCET_OPM_CLEAR, 0, 0, 16'h0003, 16'h0004);
    w(40);
    chk(16'(per_w), 16'h0005);
    chk(16'(per_i), 16'h0005);
    wr(`PCET_A_OUTPUT_CTL, 16'h0000);
    w(3);
    chk({15'h0, wave_out}, 16'h0000);
    cfg(`PCET_OPM_FREE, 0, 0, 0, 0);
    w(65560);
    rd(`PCET_A_STATUS, v0);
    chk(v0, 16'h0001);
    w(5);
    rd(`PCET_A_STATUS, v0);
    chk(v0, 16'h0001);
    wr(`PCET_A_STATUS, 16'h0000);
    rd(`PCET_A_STATUS, v0);
    chk(v0, 16'h0000);
    end_sim();
  end
endmodule
